//--- core/pecp_parser.sv
// Escape command parser of the printer controller
`include "pecp_defines.svh"

// Functional notes
// - Panel command bit 0: 0 enables feed switch, 1 disables; resets to 0.
// - Disabled feed switch presses are ignored, no paper advance.
// - Feed command prints buffer then advances n lines.
// - Feed line count is used once, never stored as setting.
// - After feed, line start is next print position.
// - ESC 0x69 fires full cut.
// - ESC 0x6D fires partial cut.
// - Cuts act only at beginning of line.
// - Table command: n 0 selects page 0, 1 selects page 1.
// - Default table page from country pins; domestic gives page 1.
// - Status request sends one byte on serial builds only.
// - Status bit 2 is paper absent, bit 4 always 0.
// - DTR/DSR mode waits while DSR is mark, sends on space.
// - XON/XOFF mode sends status without looking at DSR.
// - Status request may be refused while paper end or near end.
// - Invert command bit 0 sets 180 degree printing; resets to 0.
// - Invert setting applies only at beginning of line.
// - Absolute position is low plus high times 256 dots.
// - Absolute position beyond line end is ignored.
// - Relative position moves by signed 16-bit dot offset.
// - Relative move before line start or past line end ignored.
module pecp_parser import pecp_pkg::*; #(
	parameter bit SERIAL_BUILD = 1'b1,
	parameter logic [15:0] LINE_DOTS = `PECP_LINE_DOTS
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [7:0] rx_data,
	input wire logic rx_valid,
	output logic rx_ready,
	output logic [7:0] data_out,
	output logic data_valid,
	input wire logic line_start,
	input wire logic feed_switch_input,
	input wire logic [2:0] country_pins,
	input wire logic paper_absent,
	input wire logic paper_near_end,
	input wire logic dsr_mark,
	input wire logic flow_xon,
	input wire logic tx_ready,
	output logic [7:0] tx_data,
	output logic tx_valid,
	output pecp_mech_s mech,
	output logic switch_feed,
	output logic switch_disabled,
	output logic table_page,
	output logic invert_print,
	output logic [15:0] print_pos,
	output logic pos_update
);
	// ************************************************************
	// Synchronised pins
	// ************************************************************
	logic [3:0] pins_s;
	pecp_sync #(.WIDTH(4)) u_sync (
		.clock(clock),
		.reset_n(reset_n),
		.din({feed_switch_input, paper_absent, paper_near_end, dsr_mark}),
		.dout(pins_s)
	);
	logic [2:0] country_s;
	pecp_sync #(.WIDTH(3)) u_sync_cty (
		.clock(clock),
		.reset_n(reset_n),
		.din(country_pins),
		.dout(country_s)
	);
	wire sw_s = pins_s[3];
	wire paper_s = pins_s[2];
	wire near_s = pins_s[1];
	wire dsr_s = pins_s[0];

	// ************************************************************
	// Parser state
	// ************************************************************
	pecp_state_e state_q, state_d;
	logic is_abs_q;
	logic [7:0] lo_q;
	logic sw_prev_q;
	logic [1:0] strap_cnt_q;
	logic status_pend_q;

	wire take = rx_valid && rx_ready;
	wire [15:0] abs_pos = {rx_data, lo_q};
	wire [15:0] rel_pos = print_pos + {rx_data, lo_q};
	wire rel_left = rx_data[7];
	wire rel_bad = rel_left ? (rel_pos > print_pos) : (rel_pos < print_pos || rel_pos > LINE_DOTS);
	wire abs_bad = (abs_pos > LINE_DOTS) || (rx_data > 8'h01);
	wire pos_bad = is_abs_q ? abs_bad : rel_bad;
	// Busy on paper end or near end holds the stream off, as does a waiting status byte
	wire busy = paper_s || near_s;
	wire tx_go = status_pend_q && (flow_xon || !dsr_s);
	wire [7:0] status_byte = 8'h00 | (8'h01 << `PECP_STAT_PAPER_BIT);

	always_comb begin
		state_d = state_q;
		if (take) begin
			case (state_q)
				PECP_IDLE: state_d = (rx_data == `PECP_ESC) ? PECP_ESC_SEEN : PECP_IDLE;
				PECP_ESC_SEEN: begin
					case (rx_data)
						`PECP_CMD_PANEL: state_d = PECP_PANEL1;
						`PECP_CMD_FEED: state_d = PECP_FEED_N;
						`PECP_CMD_TABLE: state_d = PECP_TABLE_N;
						`PECP_CMD_INVERT: state_d = PECP_INVERT_N;
						`PECP_CMD_ABS: state_d = PECP_POS_LO;
						`PECP_CMD_REL: state_d = PECP_POS_LO;
						default: state_d = PECP_IDLE;
					endcase
				end
				PECP_PANEL1: state_d = (rx_data == `PECP_CMD_PANEL2) ? PECP_PANEL2 : PECP_IDLE;
				PECP_POS_LO: state_d = PECP_POS_HI;
				default: state_d = PECP_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= PECP_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			is_abs_q <= 1'b0;
			lo_q <= 8'h00;
		end else if (take) begin
			if (state_q == PECP_ESC_SEEN) begin
				is_abs_q <= (rx_data == `PECP_CMD_ABS);
			end
			if (state_q == PECP_POS_LO) begin
				lo_q <= rx_data;
			end
		end
	end

	// ************************************************************
	// Settings
	// ************************************************************
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			switch_disabled <= `PECP_RST_SWITCH_OFF;
			invert_print <= `PECP_RST_INVERT;
			table_page <= 1'b0;
			strap_cnt_q <= 2'h0;
		end else begin
			// Strap is read only once the pin synchroniser has filled
			if (strap_cnt_q != `PECP_STRAP_DONE) begin
				strap_cnt_q <= strap_cnt_q + 2'h1;
			end
			if (strap_cnt_q == `PECP_STRAP_LOAD) begin
				table_page <= (country_s == `PECP_DOMESTIC_COUNTRY);
			end else if (take && state_q == PECP_TABLE_N && rx_data <= 8'h01) begin
				table_page <= rx_data[0];
			end
			if (take && state_q == PECP_PANEL2) begin
				switch_disabled <= rx_data[0];
			end
			if (take && state_q == PECP_INVERT_N && line_start) begin
				invert_print <= rx_data[0];
			end
		end
	end

	// ************************************************************
	// Mechanism strobes and position
	// ************************************************************
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			mech <= '0;
			switch_feed <= 1'b0;
			sw_prev_q <= 1'b0;
			print_pos <= 16'h0000;
			pos_update <= 1'b0;
		end else begin
			mech.full_cut <= take && state_q == PECP_ESC_SEEN && rx_data == `PECP_CMD_FULL && line_start;
			mech.partial_cut <= take && state_q == PECP_ESC_SEEN && rx_data == `PECP_CMD_PART && line_start;
			mech.feed_go <= take && state_q == PECP_FEED_N;
			// Count is passed with the strobe only and cleared after it
			mech.feed_lines <= (take && state_q == PECP_FEED_N) ? rx_data : 8'h00;
			sw_prev_q <= sw_s;
			switch_feed <= sw_s && !sw_prev_q && !switch_disabled;
			pos_update <= 1'b0;
			if (take && state_q == PECP_FEED_N) begin
				print_pos <= 16'h0000;
				pos_update <= 1'b1;
			end else if (take && state_q == PECP_POS_HI && !pos_bad) begin
				print_pos <= is_abs_q ? abs_pos : rel_pos;
				pos_update <= 1'b1;
			end
		end
	end

	// ************************************************************
	// Status reply and stream handshake
	// ************************************************************
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			status_pend_q <= 1'b0;
			tx_valid <= 1'b0;
			tx_data <= 8'h00;
			rx_ready <= 1'b0;
			data_out <= 8'h00;
			data_valid <= 1'b0;
		end else begin
			rx_ready <= !busy && !status_pend_q && !tx_valid && !take;
			data_valid <= take && state_q == PECP_IDLE && rx_data != `PECP_ESC;
			data_out <= rx_data;
			if (take && state_q == PECP_ESC_SEEN && rx_data == `PECP_CMD_STATUS && SERIAL_BUILD) begin
				status_pend_q <= 1'b1;
			end else if (tx_go && !tx_valid) begin
				status_pend_q <= 1'b0;
			end
			if (tx_go && !tx_valid) begin
				tx_valid <= 1'b1;
				tx_data <= paper_s ? status_byte : 8'h00;
			end else if (tx_valid && tx_ready) begin
				tx_valid <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	a_feed_strobe: assert property (@(posedge clock) disable iff (!reset_n)
		(take && state_q == PECP_FEED_N) |=> mech.feed_go && mech.feed_lines == $past(rx_data))
		else $error("feed strobe missing");
	a_feed_once: assert property (@(posedge clock) disable iff (!reset_n)
		mech.feed_go |=> !mech.feed_go && mech.feed_lines == 8'h00)
		else $error("feed count retained");
	a_cut_line: assert property (@(posedge clock) disable iff (!reset_n)
		(mech.full_cut || mech.partial_cut) |-> $past(line_start))
		else $error("cut off line start");
	a_switch_off: assert property (@(posedge clock) disable iff (!reset_n)
		switch_feed |-> !$past(switch_disabled))
		else $error("disabled switch fed");
	a_status_one: assert property (@(posedge clock) disable iff (!reset_n)
		$rose(tx_valid) |-> !status_pend_q)
		else $error("status sent twice");
	a_dsr_hold: assert property (@(posedge clock) disable iff (!reset_n)
		(status_pend_q && !flow_xon && dsr_s) |=> !$rose(tx_valid))
		else $error("sent under dsr mark");
	a_stat_bit4: assert property (@(posedge clock) disable iff (!reset_n)
		$rose(tx_valid) |-> !tx_data[`PECP_STAT_FIXED_BIT] && tx_data[`PECP_STAT_PAPER_BIT] == $past(paper_s, 1))
		else $error("status encoding wrong");
	a_pos_range: assert property (@(posedge clock) disable iff (!reset_n)
		pos_update |-> print_pos <= LINE_DOTS)
		else $error("position past line end");
	a_return_idle: assert property (@(posedge clock) disable iff (!reset_n)
		(take && state_q == PECP_POS_HI) |=> state_q == PECP_IDLE)
		else $error("parser stuck");

	// Reference values for the checks, the relative sum worked out in wider signed arithmetic
	wire rx_bit0 = rx_data[0];
	wire signed [17:0] rel_chk = $signed({2'h0, print_pos}) + $signed({{2{rx_data[7]}}, rx_data, lo_q});
	wire [15:0] rel_sum = rel_chk[15:0];
	wire rel_fits = !rel_chk[17] && (rel_chk[16:0] <= {1'b0, LINE_DOTS});
	wire abs_fits = (rx_data <= 8'h01) && ({rx_data, lo_q} <= LINE_DOTS);
	sequence s_esc_code(logic [7:0] code);
		take && state_q == PECP_ESC_SEEN && rx_data == code;
	endsequence
	sequence s_cut_ok(logic [7:0] code);
		take && state_q == PECP_ESC_SEEN && rx_data == code && line_start;
	endsequence
	sequence s_param(pecp_state_e st);
		take && state_q == st;
	endsequence
	a_tx_hold: assert property (@(posedge clock) disable iff (!reset_n)
		(tx_valid && !tx_ready) |=> tx_valid && $stable(tx_data))
		else $error("status byte dropped");
	a_panel_walk: assert property (@(posedge clock) disable iff (!reset_n)
		s_esc_code(`PECP_CMD_PANEL) |=> state_q == PECP_PANEL1)
		else $error("panel prefix lost");
	a_panel_bit: assert property (@(posedge clock) disable iff (!reset_n)
		s_param(PECP_PANEL2) |=> switch_disabled == $past(rx_bit0))
		else $error("panel bit not applied");
	a_switch_edge: assert property (@(posedge clock) disable iff (!reset_n)
		(sw_s && !sw_prev_q && !switch_disabled) |=> switch_feed)
		else $error("enabled press lost");
	a_switch_block: assert property (@(posedge clock) disable iff (!reset_n)
		switch_disabled |=> !switch_feed)
		else $error("blocked press fed");
	a_feed_walk: assert property (@(posedge clock) disable iff (!reset_n)
		s_esc_code(`PECP_CMD_FEED) |=> state_q == PECP_FEED_N)
		else $error("feed code lost");
	a_feed_home: assert property (@(posedge clock) disable iff (!reset_n)
		s_param(PECP_FEED_N) |=> print_pos == 16'h0000 && pos_update)
		else $error("feed left position");
	a_full_fire: assert property (@(posedge clock) disable iff (!reset_n)
		s_cut_ok(`PECP_CMD_FULL) |=> mech.full_cut && !mech.partial_cut)
		else $error("full cut missing");
	a_part_fire: assert property (@(posedge clock) disable iff (!reset_n)
		s_cut_ok(`PECP_CMD_PART) |=> mech.partial_cut && !mech.full_cut)
		else $error("partial cut missing");
	a_table_sel: assert property (@(posedge clock) disable iff (!reset_n)
		(take && state_q == PECP_TABLE_N && rx_data <= 8'h01 && strap_cnt_q == `PECP_STRAP_DONE) |=>
		table_page == $past(rx_bit0))
		else $error("table page not selected");
	a_table_strap: assert property (@(posedge clock) disable iff (!reset_n)
		(strap_cnt_q == `PECP_STRAP_LOAD) |=> table_page == ($past(country_s) == `PECP_DOMESTIC_COUNTRY))
		else $error("strap page wrong");
	a_status_arm: assert property (@(posedge clock) disable iff (!reset_n)
		s_esc_code(`PECP_CMD_STATUS) |=> status_pend_q == SERIAL_BUILD)
		else $error("status request mishandled");
	a_xon_send: assert property (@(posedge clock) disable iff (!reset_n)
		(status_pend_q && flow_xon && !tx_valid) |=> tx_valid)
		else $error("xon status held");
	a_busy_refuse: assert property (@(posedge clock) disable iff (!reset_n)
		(busy || status_pend_q || tx_valid) |=> !rx_ready)
		else $error("byte accepted while busy");
	a_invert_set: assert property (@(posedge clock) disable iff (!reset_n)
		(take && state_q == PECP_INVERT_N && line_start) |=> invert_print == $past(rx_bit0))
		else $error("invert bit not applied");
	a_invert_hold: assert property (@(posedge clock) disable iff (!reset_n)
		(take && state_q == PECP_INVERT_N && !line_start) |=> $stable(invert_print))
		else $error("invert applied mid line");
	a_abs_walk: assert property (@(posedge clock) disable iff (!reset_n)
		s_esc_code(`PECP_CMD_ABS) |=> state_q == PECP_POS_LO && is_abs_q)
		else $error("absolute code lost");
	a_rel_walk: assert property (@(posedge clock) disable iff (!reset_n)
		s_esc_code(`PECP_CMD_REL) |=> state_q == PECP_POS_LO && !is_abs_q)
		else $error("relative code lost");
	a_abs_set: assert property (@(posedge clock) disable iff (!reset_n)
		(take && state_q == PECP_POS_HI && is_abs_q && abs_fits) |=> pos_update && print_pos == {$past(rx_data), $past(lo_q)})
		else $error("absolute position wrong");
	a_abs_drop: assert property (@(posedge clock) disable iff (!reset_n)
		(take && state_q == PECP_POS_HI && is_abs_q && !abs_fits) |=> !pos_update && $stable(print_pos))
		else $error("absolute overrun taken");
	a_rel_move: assert property (@(posedge clock) disable iff (!reset_n)
		(take && state_q == PECP_POS_HI && !is_abs_q && rel_fits) |=> pos_update && print_pos == $past(rel_sum))
		else $error("relative position wrong");
	a_rel_drop: assert property (@(posedge clock) disable iff (!reset_n)
		(take && state_q == PECP_POS_HI && !is_abs_q && !rel_fits) |=> !pos_update && $stable(print_pos))
		else $error("relative overrun taken");
	a_data_pass: assert property (@(posedge clock) disable iff (!reset_n)
		(take && state_q == PECP_IDLE && rx_data != `PECP_ESC) |=> data_valid && data_out == $past(rx_data))
		else $error("print data lost");
	a_param_idle: assert property (@(posedge clock) disable iff (!reset_n)
		s_param(PECP_TABLE_N) |=> state_q == PECP_IDLE)
		else $error("parameter not closed");
	a_take_gap: assert property (@(posedge clock) disable iff (!reset_n)
		take |=> !rx_ready)
		else $error("back to back take");
endmodule : pecp_parser

//--- inc/pecp_defines.svh
// Constants of the escape command parser
`ifndef PECP_DEFINES_SVH
`define PECP_DEFINES_SVH
`define PECP_ESC 8'h1B
`define PECP_CMD_PANEL 8'h63
`define PECP_CMD_PANEL2 8'h35
`define PECP_CMD_FEED 8'h64
`define PECP_CMD_FULL 8'h69
`define PECP_CMD_PART 8'h6D
`define PECP_CMD_TABLE 8'h74
`define PECP_CMD_STATUS 8'h76
`define PECP_CMD_INVERT 8'h7B
`define PECP_CMD_ABS 8'h24
`define PECP_CMD_REL 8'h5C
`define PECP_STAT_PAPER_BIT 2
`define PECP_STAT_FIXED_BIT 4
`define PECP_LINE_DOTS 16'h0180
`define PECP_RST_SWITCH_OFF 1'b0
`define PECP_RST_INVERT 1'b0
`define PECP_DOMESTIC_COUNTRY 3'h0
`define PECP_STRAP_LOAD 2'h2
`define PECP_STRAP_DONE 2'h3
`endif

//--- inc/pecp_pkg.sv
// Types of the escape command parser
package pecp_pkg;
	typedef enum logic [3:0] {
		PECP_IDLE = 4'b0000,
		PECP_ESC_SEEN = 4'b0001,
		PECP_PANEL1 = 4'b0010,
		PECP_PANEL2 = 4'b0011,
		PECP_FEED_N = 4'b0100,
		PECP_TABLE_N = 4'b0101,
		PECP_INVERT_N = 4'b0110,
		PECP_POS_LO = 4'b0111,
		PECP_POS_HI = 4'b1000
	} pecp_state_e;
	typedef struct packed {
		logic full_cut;
		logic partial_cut;
		logic feed_go;
		logic [7:0] feed_lines;
	} pecp_mech_s;
endpackage : pecp_pkg

//--- core/pecp_sync.sv
// Two-flop synchroniser for pin inputs
module pecp_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_q;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			meta_q <= '0;
			dout <= '0;
		end else begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule : pecp_sync

//--- testbench/pecp_host.sv
// Host model that offers bytes to the parser and takes status bytes back
module pecp_host (
	input wire logic clock,
	input wire logic rx_ready,
	output logic [7:0] rx_data,
	output logic rx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	int tx_delay = 0;
	int wait_cnt = 0;
	int n_status = 0;
	logic [7:0] last_status = 8'h00;
	initial begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
	end
	// ****************
	// Status byte sink
	// ****************
	// Answers after tx_delay cycles so both prompt and slow replies occur
	always @(negedge clock) begin
		if (tx_valid === 1'b1 && !tx_ready) begin
			tx_ready <= (wait_cnt >= tx_delay);
			wait_cnt <= wait_cnt + 1;
		end else begin
			tx_ready <= 1'b0;
			wait_cnt <= 0;
		end
	end
	always @(posedge clock) begin
		if (tx_valid === 1'b1 && tx_ready) begin
			last_status <= tx_data;
			n_status <= n_status + 1;
		end
	end
	// Holds the byte until taken; gives up after 200 cycles without ready so no reply is relied on
	task send(input logic [7:0] b);
		int i;
		i = 0;
		@(negedge clock);
		rx_data = b;
		rx_valid = 1'b1;
		// Ready seen at a falling edge holds over the next rising edge, which takes the byte
		while (rx_ready !== 1'b1 && i < 200) begin
			@(negedge clock);
			i++;
		end
		@(negedge clock);
		rx_valid = 1'b0;
		rx_data = ~b;
	endtask : send
endmodule : pecp_host

//--- testbench/tb_top.sv
// Self-checking testbench of the escape command parser
module tb_top import pecp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock, reset_n, rx_valid, rx_ready, data_valid, line_start, feed_switch_input;
	logic paper_absent, paper_near_end, dsr_mark, flow_xon, tx_ready, tx_valid;
	logic switch_feed, switch_disabled, table_page, invert_print, pos_update;
	logic [7:0] rx_data, data_out, tx_data, seen_lines, seen_data;
	logic [2:0] country_pins;
	logic [15:0] print_pos;
	pecp_mech_s mech;
	int n_mismatch = 0;
	int n_compared = 0;
	int n_full = 0;
	int n_part = 0;
	int n_sw = 0;
	int n_pos = 0;
	pecp_parser pecp_parser_inst (.clock, .reset_n, .rx_data, .rx_valid, .rx_ready, .data_out, .data_valid,
		.line_start, .feed_switch_input, .country_pins, .paper_absent, .paper_near_end, .dsr_mark, .flow_xon,
		.tx_ready, .tx_data, .tx_valid, .mech, .switch_feed, .switch_disabled, .table_page, .invert_print,
		.print_pos, .pos_update);
	pecp_host pecp_host_inst (.clock, .rx_ready, .rx_data, .rx_valid, .tx_data, .tx_valid, .tx_ready);
	// ***************
	// Helpers
	// ***************
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	always @(negedge clock) begin
		if (mech.full_cut === 1'b1) n_full++;
		if (mech.partial_cut === 1'b1) n_part++;
		if (switch_feed === 1'b1) n_sw++;
		if (pos_update === 1'b1) n_pos++;
		if (mech.feed_go === 1'b1) seen_lines = mech.feed_lines;
		if (data_valid === 1'b1) seen_data = data_out;
	end
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task cmd(input logic [7:0] c, input int n = 0, input logic [7:0] p = 8'h00, input logic [7:0] q = 8'h00);
		pecp_host_inst.send(8'h1B);
		pecp_host_inst.send(c);
		if (n > 0) pecp_host_inst.send(p);
		if (n > 1) pecp_host_inst.send(q);
		repeat (3) @(negedge clock);
	endtask : cmd
	task press;
		feed_switch_input = 1'b1;
		repeat (6) @(negedge clock);
		feed_switch_input = 1'b0;
		repeat (4) @(negedge clock);
	endtask : press
	task end_of_test;
		$display("mismatches %0d comparisons %0d", n_mismatch, n_compared);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (6000) @(posedge clock);
		n_mismatch++;
		end_of_test();
	end
	// ***************
	// Tests
	// ***************
	initial begin
		{reset_n, feed_switch_input, paper_absent, paper_near_end, dsr_mark, flow_xon} = 6'h00;
		line_start = 1'b1;
		country_pins = 3'h0;
		repeat (6) @(negedge clock);
		reset_n = 1'b1;
		repeat (4) @(negedge clock);
		chk("table_page", 1, table_page);
		chk("switch_disabled", 0, switch_disabled);
		chk("invert_print", 0, invert_print);
		cmd(8'h63, 2, 8'h35, 8'hFF);
		chk("switch_disabled", 1, switch_disabled);
		press();
		chk("switch_feed", 0, n_sw[15:0]);
		cmd(8'h63, 2, 8'h35, 8'hFE);
		press();
		chk("switch_feed", 1, n_sw[15:0]);
		cmd(8'h24, 2, 8'h7F, 8'h01);
		chk("print_pos", 16'h017F, print_pos);
		cmd(8'h24, 2, 8'h90, 8'h01);
		chk("print_pos", 16'h017F, print_pos);
		cmd(8'h5C, 2, 8'h7F, 8'hFE);
		chk("print_pos", 16'h017F, print_pos);
		cmd(8'h5C, 2, 8'h3E, 8'hFF);
		chk("print_pos", 16'h017F - 16'd194, print_pos);
		cmd(8'h5C, 2, 8'h00, 8'h01);
		chk("print_pos", 16'h00BD, print_pos);
		chk("pos_update", 2, n_pos[15:0]);
		pecp_host_inst.send(8'h41);
		repeat (2) @(negedge clock);
		chk("data_out", 8'h41, seen_data);
		cmd(8'h64, 1, 8'hFF);
		chk("feed_lines", 8'hFF, seen_lines);
		chk("print_pos", 16'h0000, print_pos);
		chk("feed_lines idle", 8'h00, mech.feed_lines);
		cmd(8'h69);
		chk("full_cut", 1, n_full);
		cmd(8'h6D);
		chk("partial_cut", 1, n_part);
		line_start = 1'b0;
		cmd(8'h69);
		cmd(8'h6D);
		cmd(8'h7B, 1, 8'h01);
		chk("cuts", 16'h0101, {n_full[7:0], n_part[7:0]});
		chk("invert_print", 0, invert_print);
		line_start = 1'b1;
		cmd(8'h7B, 1, 8'hFF);
		chk("invert_print", 1, invert_print);
		cmd(8'h7B, 1, 8'hFE);
		chk("invert_print", 0, invert_print);
		cmd(8'h74, 1, 8'h00);
		chk("table_page", 0, table_page);
		cmd(8'h74, 1, 8'h01);
		chk("table_page", 1, table_page);
		dsr_mark = 1'b1;
		cmd(8'h76);
		paper_absent = 1'b1;
		repeat (10) @(negedge clock);
		chk("status held", 0, pecp_host_inst.n_status[15:0]);
		dsr_mark = 1'b0;
		repeat (10) @(negedge clock);
		chk("status count", 1, pecp_host_inst.n_status[15:0]);
		chk("status bits", 8'h04, pecp_host_inst.last_status & 8'h14);
		paper_absent = 1'b0;
		repeat (4) @(negedge clock);
		{flow_xon, dsr_mark} = 2'b11;
		pecp_host_inst.tx_delay = 5;
		cmd(8'h76);
		repeat (15) @(negedge clock);
		chk("status xon", 2, pecp_host_inst.n_status[15:0]);
		{flow_xon, dsr_mark, paper_near_end} = 3'b001;
		repeat (5) @(negedge clock);
		chk("rx_ready busy", 0, rx_ready);
		country_pins = 3'h5;
		reset_n = 1'b0;
		repeat (2) @(negedge clock);
		reset_n = 1'b1;
		repeat (4) @(negedge clock);
		chk("table_page", 0, table_page);
		chk("switch_disabled", 0, switch_disabled);
		end_of_test();
	end
endmodule : tb_top
